// ### hw/rsc_map.svh
/*
  Register offsets, field positions, codes and delay counts of the
  reset source control block.
  Assumes a 50 MHz system clock and a 32-bit APB register bus.
*/
`ifndef RSC_MAP_SVH
`define RSC_MAP_SVH

// ==========================================================
// Register byte offsets
`define RSC_OFF_CTRL   8'h00
`define RSC_OFF_FLAGS  8'h04
`define RSC_OFF_STAT   8'h08

// ==========================================================
// Pin function codes and power-on value
`define RSC_CODE_GPIO  8'h55
`define RSC_CODE_PIN   8'haa
`define RSC_CTRL_POR   8'h55

// ==========================================================
// Cause flag bit positions
`define RSC_BIT_CONTROL_REG_RESET_FLAG   3
`define RSC_BIT_LOW_VOLTAGE_RESET_FLAG   2
`define RSC_BIT_WRF    0

// ==========================================================
// Timing: clock rate, delays in ns, derived cycle counts
`define RSC_CLK_MHZ     50
`define RSC_PIN_DLY_NS  16000
`define RSC_SOFT_DLY_NS 45000
`define RSC_PIN_DLY_CYC ((`RSC_PIN_DLY_NS * `RSC_CLK_MHZ + 999) / 1000)
`define RSC_SOFT_DLY_CYC ((`RSC_SOFT_DLY_NS * `RSC_CLK_MHZ + 999) / 1000)

`endif

// ### hw/rsc_pkg.sv
/*
  Types shared by the reset source control modules.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package rsc_pkg;
  // Sequencer states
  typedef enum logic [1:0] {
    ST_HOLD  = 2'b00,
    ST_DELAY = 2'b01,
    ST_RUN   = 2'b10
  } rsc_state_t;

  // Delay counter word
  typedef logic [11:0] rsc_cnt_t;
endpackage

`default_nettype wire

// ### hw/rsc_tmr_if.sv
/*
  Handshake between the sequencer and one delay timer.
  Assumes both ends run on sys_clk.
*/
`default_nettype none

interface rsc_tmr_if;
  import rsc_pkg::*;
  logic     start;  // Load pulse
  rsc_cnt_t load;   // Cycles to run
  logic     busy;   // Counting
  logic     done;   // Last cycle pulse
  modport timer (input start, input load, output busy, output done);
  modport user  (output start, output load, input busy, input done);
endinterface

`default_nettype wire

// ### hw/rsc_delay_timer.sv
/*
  One-shot down counter timing a reset delay.
  Assumes start is a one-cycle pulse from the sequencer.
*/
`default_nettype none

module rsc_delay_timer (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Sequencer side
  rsc_tmr_if.timer tif
);
  import rsc_pkg::*;

  rsc_cnt_t cntQ;      // Remaining cycles
  rsc_cnt_t elapsedQ;  // Cycles since start, checking only
  rsc_cnt_t loadQ;     // Last load, checking only

  // ==========================================================
  // Counter; a new start reloads even while busy
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cntQ <= 12'h000;
    end else if (tif.start) begin
      cntQ <= tif.load;
    end else if (cntQ != 12'h000) begin
      cntQ <= cntQ - 12'h001;
    end
  end

  assign tif.busy = (cntQ != 12'h000);
  assign tif.done = (cntQ == 12'h001);

  // Helper counters for the exact-length check
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      elapsedQ <= 12'h000;
      loadQ    <= 12'h000;
    end else if (tif.start) begin
      elapsedQ <= 12'h000;
      loadQ    <= tif.load;
    end else if (tif.busy) begin
      elapsedQ <= elapsedQ + 12'h001;
    end
  end

  AST_TMR_EXACT: assert property (@(posedge sys_clk) disable iff (!nrst)
    tif.done |-> elapsedQ == 12'(loadQ - 12'h001))
    else $error("delay timer ended at wrong count");

endmodule // rsc_delay_timer

`default_nettype wire

// ### hw/rsc_top.sv
/*
  Reset source control: merges power-on, pin, low-voltage and
  watchdog resets into one core reset, owns the pin function
  control register and the reset cause flags, reached over APB.
  Assumes the watchdog reports overflow and bad-code resets as
  one-cycle pulses on sys_clk; the pin and low-voltage detector
  are asynchronous.
*/
`default_nettype none
`include "rsc_map.svh"

module rsc_top (
  // Clock and power-on reset
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Reset sources
  input  wire logic        resetPinIn,
  input  wire logic        lowVoltIn,
  input  wire logic        wdtOverflow,
  input  wire logic        wdtCodeReset,
  input  wire logic        cpuSleep,
  // Reset results
  output logic             coreRst,
  output logic             porRst,
  output logic             portInit,
  output logic             pinIsReset
);
  import rsc_pkg::*;

  // ==========================================================
  // Declarations
  rsc_state_t  stateQ, stateD;   // Sequencer state
  logic [7:0]  ctrlQ, ctrlD;     // Pin function control
  logic        rstfQ, lvrfQ, wrfQ; // Cause flags
  logic        warmQ;            // Current reset is warm
  logic        pinS1Q, pinS2Q;   // Pin synchroniser
  logic        lvS1Q, lvS2Q;     // Low-voltage synchroniser
  logic        coreRstQ, porRstQ, portInitQ, pinIsRstQ;
  logic [31:0] prdataQ;
  logic        preadyQ, pslverrQ;
  logic        pinStart;         // Start of pin delay

  rsc_tmr_if pinTif ();          // Post-reset delay timer
  rsc_tmr_if softTif ();         // Software reset delay timer

  // ==========================================================
  // Input synchronisers; pin idles high
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pinS1Q <= 1'b1;
      pinS2Q <= 1'b1;
      lvS1Q  <= 1'b0;
      lvS2Q  <= 1'b0;
    end else begin
      pinS1Q <= resetPinIn;
      pinS2Q <= pinS1Q;
      lvS1Q  <= lowVoltIn;
      lvS2Q  <= lvS1Q;
    end
  end

  // ==========================================================
  // Reset source merge
  // two valid codes only
  wire ctrlInvalid = (ctrlQ != `RSC_CODE_GPIO) && (ctrlQ != `RSC_CODE_PIN);
  wire pinRst   = pinIsRstQ && !pinS2Q;
  wire softDone = softTif.done;
  wire holdSrc  = pinRst || lvS2Q;
  wire evtSrc   = wdtOverflow || wdtCodeReset || softDone;
  wire trig     = holdSrc || evtSrc;
  // Warm only if watchdog overflow in sleep and nothing else
  wire warmOnly = wdtOverflow && cpuSleep && !holdSrc && !wdtCodeReset
                  && !softDone;
  wire warmD    = trig ? (warmOnly && (stateQ == ST_RUN || warmQ)) : warmQ;

  // ==========================================================
  // Sequencer next state
  always_comb begin
    stateD   = stateQ;
    pinStart = 1'b0;
    if (trig) begin
      stateD = ST_HOLD;
    end else begin
      case (stateQ)
        ST_HOLD: begin
          stateD   = ST_DELAY;
          pinStart = 1'b1;
        end
        ST_DELAY: begin
          if (pinTif.done) begin
            stateD = ST_RUN;
          end
        end
        ST_RUN: begin
          stateD = ST_RUN;
        end
        default: begin
          stateD = ST_HOLD;
        end
      endcase
    end
  end

  assign pinTif.start = pinStart;
  assign pinTif.load  = 12'(`RSC_PIN_DLY_CYC);

  assign softTif.start = (stateQ == ST_RUN) && ctrlInvalid
                         && !softTif.busy && !trig;
  assign softTif.load  = 12'(`RSC_SOFT_DLY_CYC);

  // Delay timers
  rsc_delay_timer u_pin_tmr (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .tif     (pinTif.timer)
  );

  rsc_delay_timer u_soft_tmr (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .tif     (softTif.timer)
  );

  // ==========================================================
  // APB decode; one wait state before pready
  wire apbAcc   = psel && penable;
  wire ansStep  = apbAcc && !preadyQ;
  wire wrDo     = apbAcc && preadyQ && pwrite;
  wire hitCtrl  = (paddr == `RSC_OFF_CTRL);
  wire hitFlags = (paddr == `RSC_OFF_FLAGS);
  wire hitStat  = (paddr == `RSC_OFF_STAT);
  wire hitAny   = hitCtrl || hitFlags || hitStat;
  wire wrCtrl   = wrDo && hitCtrl;
  wire wrFlags  = wrDo && hitFlags;
  wire runEntry = (stateQ != ST_RUN) && (stateD == ST_RUN);

  wire [7:0] flagsRd = {4'h0, rstfQ, lvrfQ, 1'b0, wrfQ};
  wire [7:0] statRd  = {3'h0, softTif.busy, warmQ, porRstQ, coreRstQ, pinIsRstQ};
  wire [7:0] rdMux   = hitCtrl  ? ctrlQ :
                       hitFlags ? flagsRd :
                       hitStat  ? statRd : 8'h00;

  // APB answer registers
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      preadyQ  <= 1'b0;
      prdataQ  <= 32'h0000_0000;
      pslverrQ <= 1'b0;
    end else begin
      preadyQ  <= ansStep;
      prdataQ  <= (ansStep && !pwrite) ? {24'h000000, rdMux} : 32'h0000_0000;
      pslverrQ <= ansStep && !hitAny;
    end
  end

  // ==========================================================
  // Control register next value
  // restore on leaving a non-warm reset
  assign ctrlD = (runEntry && !warmQ) ? `RSC_CTRL_POR :
                 wrCtrl ? pwdata[7:0] : ctrlQ;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ctrlQ <= `RSC_CTRL_POR;
    end else begin
      ctrlQ <= ctrlD;
    end
  end

  // ==========================================================
  // Cause flags; set wins over a clearing write
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rstfQ <= 1'b0;
      lvrfQ <= 1'b0;
      wrfQ  <= 1'b0;
    end else begin
      // cleared only by a zero write
      rstfQ <= softDone || (rstfQ && !(wrFlags && !pwdata[`RSC_BIT_CONTROL_REG_RESET_FLAG]));
      lvrfQ <= lvS2Q || (lvrfQ && !(wrFlags && !pwdata[`RSC_BIT_LOW_VOLTAGE_RESET_FLAG]));
      wrfQ  <= wdtCodeReset || (wrfQ && !(wrFlags && !pwdata[`RSC_BIT_WRF]));
    end
  end

  // ==========================================================
  // Sequencer and reset outputs
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      stateQ    <= ST_HOLD;
      warmQ     <= 1'b0;
      coreRstQ  <= 1'b1;
      porRstQ   <= 1'b1;
      portInitQ <= 1'b1;
      pinIsRstQ <= 1'b0;
    end else begin
      stateQ    <= stateD;
      warmQ     <= warmD;
      coreRstQ  <= (stateD != ST_RUN);
      porRstQ   <= porRstQ && (stateD != ST_RUN);
      portInitQ <= (stateD != ST_RUN) && !warmD;
      pinIsRstQ <= (ctrlD == `RSC_CODE_PIN);
    end
  end

  assign coreRst    = coreRstQ;
  assign porRst     = porRstQ;
  assign portInit   = portInitQ;
  assign pinIsReset = pinIsRstQ;
  assign prdata     = prdataQ;
  assign pready     = preadyQ;
  assign pslverr    = pslverrQ;

  // ==========================================================
  // Checks
  // pin low forces core reset when pin is set to the reset function
  AST_PIN_HOLD: assert property (@(posedge sys_clk) disable iff (!nrst)
    pinRst |=> coreRstQ)
    else $error("selected pin low did not hold core reset");

  AST_REL_DELAY: assert property (@(posedge sys_clk) disable iff (!nrst)
    $fell(coreRstQ) |-> $past(stateQ) == ST_DELAY && $past(pinTif.done))
    else $error("core reset released without delay");

  AST_CODE_SEL: assert property (@(posedge sys_clk) disable iff (!nrst)
    (wrCtrl && !(runEntry && !warmQ)) |=> pinIsRstQ == ($past(pwdata[7:0]) == `RSC_CODE_PIN))
    else $error("pin function does not match control code");

  AST_SOFT_START: assert property (@(posedge sys_clk) disable iff (!nrst)
    (stateQ == ST_RUN && ctrlInvalid && !trig && !softTif.busy)
    |=> softTif.busy)
    else $error("invalid code did not start soft delay");

  // soft reset sets flag and resets
  AST_CONTROL_REG_RESET_FLAG_SET: assert property (@(posedge sys_clk) disable iff (!nrst)
    softDone |=> rstfQ && coreRstQ)
    else $error("soft reset flag or reset missing");

  // flag clears only by zero write
  AST_CONTROL_REG_RESET_FLAG_CLR: assert property (@(posedge sys_clk) disable iff (!nrst)
    $fell(rstfQ) |-> $past(wrFlags) && !$past(pwdata[`RSC_BIT_CONTROL_REG_RESET_FLAG]))
    else $error("control reset flag cleared without write");

  AST_LOW_VOLTAGE_RESET_FLAG_SET: assert property (@(posedge sys_clk) disable iff (!nrst)
    lvS2Q |=> lvrfQ && coreRstQ)
    else $error("low voltage flag or reset missing");

  // bad watchdog code sets its flag
  AST_WRF_SET: assert property (@(posedge sys_clk) disable iff (!nrst)
    wdtCodeReset |=> wrfQ ##1 coreRstQ)
    else $error("watchdog code flag or reset missing");

  AST_CTRL_RST: assert property (@(posedge sys_clk) disable iff (!nrst)
    (runEntry && !warmQ) |=> ctrlQ == `RSC_CTRL_POR)
    else $error("control register not restored after reset");

  AST_RSVD_ZERO: assert property (@(posedge sys_clk) disable iff (!nrst)
    (ansStep && !pwrite && hitFlags) |=> prdataQ[7:4] == 4'h0 && !prdataQ[1])
    else $error("reserved flag bits read nonzero");

  AST_PORT_INIT: assert property (@(posedge sys_clk) disable iff (!nrst)
    (coreRstQ && !warmQ) |-> portInitQ)
    else $error("cold reset did not force port init");

  AST_POR_ONCE: assert property (@(posedge sys_clk) disable iff (!nrst)
    !porRstQ |=> !porRstQ)
    else $error("power-on marker rose without power-on");

  AST_WDT_RST: assert property (@(posedge sys_clk) disable iff (!nrst)
    wdtOverflow |=> coreRstQ)
    else $error("watchdog overflow did not reset core");

  AST_PIN_IGNORED: assert property (@(posedge sys_clk) disable iff (!nrst)
    (stateQ == ST_RUN && !pinIsRstQ && !lvS2Q && !evtSrc) |=> !coreRstQ)
    else $error("core reset without an active source");

  AST_CONTROL_REG_RESET_FLAG_KEEP: assert property (@(posedge sys_clk) disable iff (!nrst)
    (wrFlags && pwdata[`RSC_BIT_CONTROL_REG_RESET_FLAG]) |=> rstfQ == ($past(rstfQ) || $past(softDone)))
    else $error("control reset flag changed by a one write");

  // low voltage flag cleared by write only
  AST_LOW_VOLTAGE_RESET_FLAG_CLR: assert property (@(posedge sys_clk) disable iff (!nrst)
    $fell(lvrfQ) |-> $past(wrFlags) && !$past(pwdata[`RSC_BIT_LOW_VOLTAGE_RESET_FLAG]))
    else $error("low voltage flag cleared without write");

  // watchdog code flag cleared by write only
  AST_WRF_CLR: assert property (@(posedge sys_clk) disable iff (!nrst)
    $fell(wrfQ) |-> $past(wrFlags) && !$past(pwdata[`RSC_BIT_WRF]))
    else $error("watchdog code flag cleared without write");

endmodule // rsc_top

`default_nettype wire

// ### tb/rsc_pin_model.sv
/*
  External reset network on the shared pin: a pull-up with an RC
  that the bench can pull low and that comes back up slowly.
  Assumes the bench drives holdLow and riseDly on sys_clk edges.
*/
`default_nettype none

module rsc_pin_model (
  // Clock
  input  wire logic       sys_clk,
  // Bench requests
  input  wire logic       holdLow,
  input  wire logic [3:0] riseDly,
  // Pin toward the block
  output logic            resetPinIn
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // RC state
  logic       pinLow_q = 1'b0;  // Capacitor discharged
  logic [3:0] cnt_q    = 4'h0;  // Cycles left to recharge

  // Slow release, so the block sees a late rising edge
  always_ff @(posedge sys_clk) begin
    if (holdLow) begin
      pinLow_q <= 1'b1;
      cnt_q    <= riseDly;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end else begin
      pinLow_q <= 1'b0;
    end
  end

  // Pull-up: a released pin reads high, never a stale value
  assign resetPinIn = ~pinLow_q;
endmodule // rsc_pin_model

`default_nettype wire

// ### tb/test_reset_source_control.sv
/*
  Self-checking bench for the reset source control block.
  Assumes the register map header and a 50 MHz sys_clk.
*/
`default_nettype none
`include "rsc_map.svh"

module test_reset_source_control;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Stimulus and observed signals
  logic        sys_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, resetPinIn, coreRst, porRst, portInit, pinIsReset;
  logic        lowVoltIn = 1'b0;
  logic        wdtOverflow = 1'b0;
  logic        wdtCodeReset = 1'b0;
  logic        cpuSleep = 1'b0;
  logic        holdLow = 1'b0;
  logic [3:0]  riseDly = 4'h0;
  logic [32:0] expQ[$];            // Expected {pslverr, prdata}
  logic [7:0]  bad;                // Invalid control code
  int          badCount = 0;
  int          nChecks = 0;
  int          seed = 32'h7f6973cd;
  int          n, d;

  always #10 sys_clk = ~sys_clk;

  rsc_top dut_u (.sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .resetPinIn(resetPinIn), .lowVoltIn(lowVoltIn),
    .wdtOverflow(wdtOverflow), .wdtCodeReset(wdtCodeReset), .cpuSleep(cpuSleep),
    .coreRst(coreRst), .porRst(porRst), .portInit(portInit), .pinIsReset(pinIsReset));
  rsc_pin_model pin_u (.sys_clk(sys_clk), .holdLow(holdLow), .riseDly(riseDly),
    .resetPinIn(resetPinIn));

  // ==========================================================
  // Reporting
  task giveVerdict;
    $display("checks %0d mismatches %0d", nChecks, badCount);
    if (badCount == 0 && nChecks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task cmpBit(input logic a, input logic e);
    nChecks++;
    if (a !== e) begin
      badCount++;
      $display("MISMATCH t=%0t got %h exp %h", $time, a, e);
    end
  endtask

  task cmpRd(input logic [32:0] a, input logic [32:0] e);
    nChecks++;
    if (a !== e) begin
      badCount++;
      $display("MISMATCH t=%0t got %h exp %h", $time, a, e);
    end
  endtask

  // ==========================================================
  // APB master: hold everything until pready is sampled
  task apb(input logic w, input logic [7:0] a, input logic [31:0] dat);
    int k;
    @(posedge sys_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= dat;
    @(posedge sys_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) begin
      badCount++;
      giveVerdict();
    end
  endtask

  task rd(input logic [7:0] a, input logic err, input logic [31:0] e);
    expQ.push_back({err, e});
    apb(1'b0, a, 32'h0);
  endtask

  // Bounded wait for a core reset level, cycles waited in n
  task waitCore(input logic v, input int lim);
    n = 0;
    while (coreRst !== v && n < lim) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= lim) begin
      badCount++;
      giveVerdict();
    end
  endtask

  // Read monitor: oldest note against each completed read
  always @(posedge sys_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && expQ.size() > 0)
      cmpRd({pslverr, prdata}, expQ.pop_front());
  end

  // ==========================================================
  // Main sequence
  initial begin
    repeat (12) @(posedge sys_clk);
    cmpBit(coreRst, 1'b1);
    cmpBit(portInit, 1'b1);
    nrst <= 1'b1;
    rd(`RSC_OFF_CTRL, 1'b0, 32'h55);
    rd(`RSC_OFF_FLAGS, 1'b0, 32'h0);
    rd(8'h0c, 1'b1, 32'h0);
    rd(`RSC_OFF_STAT, 1'b0, 32'h06);
    waitCore(1'b0, 900);
    cmpBit(porRst, 1'b0);
    // Pin as general I/O must not reset
    holdLow <= 1'b1;
    repeat (20) @(posedge sys_clk);
    cmpBit(coreRst, 1'b0);
    cmpBit(pinIsReset, 1'b0);
    holdLow <= 1'b0;
    repeat (10) @(posedge sys_clk);
    // Low supply, then its flag
    lowVoltIn <= 1'b1;
    repeat (10) @(posedge sys_clk);
    cmpBit(coreRst, 1'b1);
    lowVoltIn <= 1'b0;
    waitCore(1'b0, 900);
    rd(`RSC_OFF_FLAGS, 1'b0, 32'h04);
    // Pin reset with a slow RC release
    apb(1'b1, `RSC_OFF_CTRL, {24'h0, `RSC_CODE_PIN});
    repeat (2) @(posedge sys_clk);
    cmpBit(pinIsReset, 1'b1);
    d = $random(seed) & 15;
    riseDly <= 4'(d);
    holdLow <= 1'b1;
    repeat (50) @(posedge sys_clk);
    cmpBit(coreRst, 1'b1);
    cmpBit(porRst, 1'b0);
    holdLow <= 1'b0;
    waitCore(1'b0, 1000);
    cmpBit(n >= d + 800 && n <= d + 812, 1'b1);
    rd(`RSC_OFF_FLAGS, 1'b0, 32'h04);
    rd(`RSC_OFF_CTRL, 1'b0, 32'h55);
    // Writing ones keeps flags, zero clears
    apb(1'b1, `RSC_OFF_FLAGS, 32'hff);
    rd(`RSC_OFF_FLAGS, 1'b0, 32'h04);
    apb(1'b1, `RSC_OFF_FLAGS, 32'h0);
    rd(`RSC_OFF_FLAGS, 1'b0, 32'h0);
    // Invalid control code: delayed reset
    do bad = 8'($random(seed)); while (bad == 8'h55 || bad == 8'haa);
    apb(1'b1, `RSC_OFF_CTRL, {24'h0, bad});
    rd(`RSC_OFF_STAT, 1'b0, 32'h10);
    waitCore(1'b1, 2400);
    cmpBit(n >= 2241 && n <= 2254, 1'b1);
    waitCore(1'b0, 900);
    rd(`RSC_OFF_FLAGS, 1'b0, 32'h08);
    rd(`RSC_OFF_CTRL, 1'b0, 32'h55);
    apb(1'b1, `RSC_OFF_FLAGS, 32'h0);
    // Warm reset in sleep keeps the control code
    apb(1'b1, `RSC_OFF_CTRL, {24'h0, `RSC_CODE_PIN});
    cpuSleep    <= 1'b1;
    wdtOverflow <= 1'b1;
    @(posedge sys_clk);
    wdtOverflow <= 1'b0;
    waitCore(1'b1, 10);
    cmpBit(portInit, 1'b0);
    waitCore(1'b0, 900);
    cpuSleep <= 1'b0;
    rd(`RSC_OFF_CTRL, 1'b0, 32'haa);
    // Bad watchdog code reset
    wdtCodeReset <= 1'b1;
    @(posedge sys_clk);
    wdtCodeReset <= 1'b0;
    waitCore(1'b1, 10);
    waitCore(1'b0, 900);
    rd(`RSC_OFF_FLAGS, 1'b0, 32'h01);
    rd(`RSC_OFF_CTRL, 1'b0, 32'h55);
    // Second power-on clears the flags
    nrst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    rd(`RSC_OFF_FLAGS, 1'b0, 32'h0);
    repeat (5) @(posedge sys_clk);
    giveVerdict();
  end
endmodule // test_reset_source_control

`default_nettype wire
